/* File: core/etoc_top.v */
// Enhanced timer output-A control with AXI4-Lite register access
`timescale 1ns/10ps
`include "etoc_consts.vh"
module etoc_top #(
   parameter WIDTH = 10
) (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // AXI4-Lite write address
   input  wire [4:0]  s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [4:0]  s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Output pin A
   output wire        output_pin_a_o,
   output wire        output_pin_a_oe
);
   // Registers
   reg  [7:0]       ctrl0_ff;
   reg  [7:0]       ctrl1_ff;
   reg  [7:0]       ctrl2_ff;
   reg  [WIDTH-1:0] cmpa_ff;
   reg              on_d_ff;
   // Bus state
   reg              aw_got_ff;
   reg  [4:0]       awaddr_ff;
   reg              w_got_ff;
   reg  [31:0]      wdata_ff;
   reg  [3:0]       wstrb_ff;
   reg              bvalid_ff;
   reg  [1:0]       bresp_ff;
   reg              rvalid_ff;
   reg  [1:0]       rresp_ff;
   reg  [31:0]      rdata_ff;
   reg  [31:0]      nxt_rdata;
   reg  [1:0]       nxt_rresp;
   reg              wr_hit;
   // Timer wiring
   wire             counter_on;
   wire             restart;
   wire [1:0]       mode_a;
   wire [WIDTH-1:0] count;
   wire             dir_flag;
   wire             a_match;
   wire             p_match;
   wire             updown_en;
   wire             do_write;
   wire             ar_take;

   assign counter_on = ctrl0_ff[`ETOC_C0_ON];
   // Edge of counter_on seen against its previous value
   assign restart    = counter_on && !on_d_ff;                 // [RL4] [RL5]
   assign mode_a     = ctrl1_ff[`ETOC_C1_MODE_HI:`ETOC_C1_MODE_LO];// [RL14]
   // Centre-aligned counting only in PWM mode with a nonzero option
   assign updown_en  = (mode_a == `ETOC_MODE_PWM)
                       && (ctrl2_ff[`ETOC_C2_PWMOPT_HI:`ETOC_C2_PWMOPT_LO]
                           != 2'h0);

   etoc_counter #(
      .WIDTH (WIDTH)
   ) u_counter (
      .sys_clk              (sys_clk),
      .resetn               (resetn),
      .run                  (counter_on),
      .restart              (restart),
      .mode                 (mode_a),
      .clear_source_select  (ctrl1_ff[`ETOC_C1_CLR]),
      .updown_en            (updown_en),
      .period_compare_bits  (ctrl0_ff[`ETOC_C0_PER_HI:`ETOC_C0_PER_LO]),
      .compare_a_value      (cmpa_ff),
      .count                (count),
      .count_direction_flag (dir_flag),
      .a_match              (a_match),
      .p_match              (p_match)
   );

   etoc_out_a u_out_a (
      .sys_clk                (sys_clk),
      .resetn                 (resetn),
      .run                    (counter_on),
      .restart                (restart),
      .mode                   (mode_a),
      .action                 (ctrl1_ff[`ETOC_C1_ACT_HI:`ETOC_C1_ACT_LO]),
      .output_initial_level_a (ctrl1_ff[`ETOC_C1_INIT]),
      .output_invert_a        (ctrl1_ff[`ETOC_C1_INV]),
      .a_match                (a_match),
      .below_a                (count < cmpa_ff),
      .output_pin_a_o         (output_pin_a_o),
      .output_pin_a_oe        (output_pin_a_oe)
   );

   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready  = !w_got_ff && !bvalid_ff;
   assign do_write      = aw_got_ff && w_got_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   always @* begin
      wr_hit = (awaddr_ff == `ETOC_OFS_CTRL0)
               || (awaddr_ff == `ETOC_OFS_CTRL1)
               || (awaddr_ff == `ETOC_OFS_CTRL2)
               || (awaddr_ff == `ETOC_OFS_CMPA)
               || (awaddr_ff == `ETOC_OFS_COUNT);
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_got_ff <= 1'b0;
         awaddr_ff <= 5'h00;
         w_got_ff  <= 1'b0;
         wdata_ff  <= 32'h00000000;
         wstrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= `ETOC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[4:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `ETOC_RESP_OKAY : `ETOC_RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Register file; direction flag is hardware state, not stored
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl0_ff <= `ETOC_RST_CTRL0;
         ctrl1_ff <= `ETOC_RST_CTRL1;
         ctrl2_ff <= `ETOC_RST_CTRL2;
         cmpa_ff  <= `ETOC_RST_CMPA;
         on_d_ff  <= 1'b0;
      end else begin
         on_d_ff <= counter_on;
         if (do_write && wstrb_ff[0]) begin
            if (awaddr_ff == `ETOC_OFS_CTRL0) begin
               ctrl0_ff <= wdata_ff[7:0];
            end else if (awaddr_ff == `ETOC_OFS_CTRL1) begin
               ctrl1_ff <= wdata_ff[7:0] & 8'hFD;                   // [RL10]
            end else if (awaddr_ff == `ETOC_OFS_CTRL2) begin
               ctrl2_ff <= wdata_ff[7:0];
            end else if (awaddr_ff == `ETOC_OFS_CMPA) begin
               cmpa_ff[7:0] <= wdata_ff[7:0];
            end
         end
         if (do_write && wstrb_ff[1]
             && (awaddr_ff == `ETOC_OFS_CMPA)) begin
            cmpa_ff[WIDTH-1:8] <= wdata_ff[WIDTH-1:8];
         end
      end
   end

   // Read channel: one read at a time, answered the next cycle
   assign ar_take       = s_axi_arvalid && !rvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_rresp = `ETOC_RESP_OKAY;
      if (s_axi_araddr[4:2] == 3'h0) begin
         nxt_rdata[7:0] = ctrl0_ff;
      end else if (s_axi_araddr[4:2] == 3'h1) begin
         nxt_rdata[7:0] = {ctrl1_ff[7:2], dir_flag, ctrl1_ff[0]};   // [RL10]
      end else if (s_axi_araddr[4:2] == 3'h2) begin
         nxt_rdata[7:0] = ctrl2_ff;
      end else if (s_axi_araddr[4:2] == 3'h3) begin
         nxt_rdata[WIDTH-1:0] = cmpa_ff;
      end else if (s_axi_araddr[4:2] == 3'h4) begin
         nxt_rdata[WIDTH-1:0] = count;
      end else begin
         nxt_rresp = `ETOC_RESP_SLVERR;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `ETOC_RESP_OKAY;
      end else begin
         if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end
endmodule // etoc_top

/* File: core/etoc_consts.vh */
// Constants for the enhanced timer output-A control block
// Notes on behaviour
// [RL1] In compare mode a comparator A match drives pin A low, high or toggles it as the action field says, and a zero field leaves it alone.
// [RL2] The compare-mode action field codes are 01 low, 10 high and 11 toggle.
// [RL3] Software should ask for a match level that differs from the initial level, or a match shows no change on pin A.
// [RL4] Once pin A has changed in compare mode, a rising edge of counter_on puts it back to its initial level.
// [RL5] A rising edge of counter_on clears the counter to zero, and a falling edge holds the present count.
// [RL6] The initial-level bit sets pin A before any match in compare mode, 0 low and 1 high.
// [RL7] In PWM or single-pulse mode the initial-level bit picks the active level, 0 active low and 1 active high.
// [RL8] The initial-level bit does nothing in timer/counter mode.
// [RL9] The invert bit inverts pin A when 1 and passes it when 0, and does nothing in timer/counter mode.
// [RL10] A read-only direction flag reads 0 while counting up and 1 while counting down.
// [RL11] With clear-select at 1 the counter clears on a comparator A match, and at 0 on a comparator P match or on overflow.
// [RL12] Overflow clearing applies only when all period bits are zero, otherwise clear-select 0 clears on the P match.
// [RL13] Clear-select is ignored in PWM, single-pulse and capture modes.
// [RL14] The channel A mode field codes 00 compare, 01 capture, 10 PWM or single pulse, and 11 timer/counter.
// [RL15] Polarity inversion is the last stage before pin A, after the compare, PWM or forced level.
`ifndef ETOC_CONSTS_VH
`define ETOC_CONSTS_VH

// Register byte offsets
`define ETOC_OFS_CTRL0      5'h00
`define ETOC_OFS_CTRL1      5'h04
`define ETOC_OFS_CTRL2      5'h08
`define ETOC_OFS_CMPA       5'h0C
`define ETOC_OFS_COUNT      5'h10

// Reset values
`define ETOC_RST_CTRL0      8'h00
`define ETOC_RST_CTRL1      8'h00
`define ETOC_RST_CTRL2      8'h00
`define ETOC_RST_CMPA       10'h000

// Control zero fields
`define ETOC_C0_ON          3
`define ETOC_C0_PER_HI      2
`define ETOC_C0_PER_LO      0

// Control one fields
`define ETOC_C1_MODE_HI     7
`define ETOC_C1_MODE_LO     6
`define ETOC_C1_ACT_HI      5
`define ETOC_C1_ACT_LO      4
`define ETOC_C1_INIT        3
`define ETOC_C1_INV         2
`define ETOC_C1_DIR         1
`define ETOC_C1_CLR         0

// Control two fields
`define ETOC_C2_PWMOPT_HI   1
`define ETOC_C2_PWMOPT_LO   0

// Channel A modes
`define ETOC_MODE_CMP       2'h0
`define ETOC_MODE_CAP       2'h1
`define ETOC_MODE_PWM       2'h2
`define ETOC_MODE_TMR       2'h3

// Compare-mode actions
`define ETOC_ACT_NONE       2'h0
`define ETOC_ACT_LOW        2'h1
`define ETOC_ACT_HIGH       2'h2
`define ETOC_ACT_TOGGLE     2'h3

// PWM-mode actions
`define ETOC_PACT_INACT     2'h0
`define ETOC_PACT_ACT       2'h1
`define ETOC_PACT_PWM       2'h2
`define ETOC_PACT_PULSE     2'h3

// AXI responses
`define ETOC_RESP_OKAY      2'h0
`define ETOC_RESP_SLVERR    2'h2

`endif

/* File: core/etoc_counter.v */
// Ten-bit up/down counter with selectable clear source
`timescale 1ns/10ps
`include "etoc_consts.vh"
module etoc_counter #(
   parameter WIDTH = 10
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             resetn,
   // Control
   input  wire             run,
   input  wire             restart,
   input  wire [1:0]       mode,
   input  wire             clear_source_select,
   input  wire             updown_en,
   input  wire [2:0]       period_compare_bits,
   input  wire [WIDTH-1:0] compare_a_value,
   // Status
   output wire [WIDTH-1:0] count,
   output wire             count_direction_flag,
   output wire             a_match,
   output wire             p_match
);
   reg  [WIDTH-1:0] cnt_ff;
   reg  [WIDTH-1:0] nxt_cnt;
   reg              down_ff;
   reg              nxt_down;
   wire             top_hit;
   wire             clr_on_a;
   wire             per_zero;

   assign per_zero = (period_compare_bits == 3'h0);
   assign a_match  = run && (cnt_ff == compare_a_value);
   assign p_match  = run && !per_zero
                     && (cnt_ff == {period_compare_bits, {(WIDTH-3){1'b0}}});
   assign top_hit  = run && per_zero && (cnt_ff == {WIDTH{1'b1}});
   // Clear-select only counts in compare and timer modes [RL13]
   assign clr_on_a = clear_source_select
                     && ((mode == `ETOC_MODE_CMP) || (mode == `ETOC_MODE_TMR));
   assign count    = cnt_ff;
   assign count_direction_flag = down_ff;                           // [RL10]

   always @* begin
      nxt_cnt  = cnt_ff;
      nxt_down = down_ff;
      if (restart) begin
         nxt_cnt  = {WIDTH{1'b0}};                                  // [RL5]
         nxt_down = 1'b0;
      end else if (run) begin
         if (updown_en) begin
            // Centre-aligned: turn round at the period and at zero
            if (!down_ff && (p_match || top_hit)) begin
               nxt_down = 1'b1;
               nxt_cnt  = cnt_ff - 1'b1;
            end else if (down_ff && (cnt_ff == {WIDTH{1'b0}})) begin
               nxt_down = 1'b0;
               nxt_cnt  = cnt_ff + 1'b1;
            end else if (down_ff) begin
               nxt_cnt  = cnt_ff - 1'b1;
            end else begin
               nxt_cnt  = cnt_ff + 1'b1;
            end
         end else begin
            nxt_down = 1'b0;
            if (clr_on_a && a_match) begin
               nxt_cnt = {WIDTH{1'b0}};                             // [RL11]
            end else if (!clr_on_a && (p_match || top_hit)) begin
               nxt_cnt = {WIDTH{1'b0}};                      // [RL11] [RL12]
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
      end
   end

   // Stopped counter keeps its residual value [RL5]
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff  <= {WIDTH{1'b0}};
         down_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         down_ff <= nxt_down;
      end
   end
endmodule // etoc_counter

/* File: core/etoc_out_a.v */
// Output pin A level logic: compare actions, PWM and polarity
`timescale 1ns/10ps
`include "etoc_consts.vh"
module etoc_out_a (
   // Clock and reset
   input  wire       sys_clk,
   input  wire       resetn,
   // Control
   input  wire       run,
   input  wire       restart,
   input  wire [1:0] mode,
   input  wire [1:0] action,
   input  wire       output_initial_level_a,
   input  wire       output_invert_a,
   input  wire       a_match,
   input  wire       below_a,
   // Pin
   output wire       output_pin_a_o,
   output wire       output_pin_a_oe
);
   reg  lvl_ff;
   reg  nxt_lvl;
   reg  pulse_ff;
   reg  nxt_pulse;
   reg  oe_ff;
   reg  pin_ff;
   reg  raw;
   wire act;
   wire inact;

   assign act   = output_initial_level_a;                          // [RL7]
   assign inact = ~output_initial_level_a;

   always @* begin
      nxt_lvl   = lvl_ff;
      nxt_pulse = pulse_ff;
      if (restart) begin
         nxt_lvl   = output_initial_level_a;                 // [RL4] [RL6]
         nxt_pulse = 1'b1;
      end else if (!run && (mode == `ETOC_MODE_CMP)) begin
         // Before the counter starts the pin follows the initial level
         nxt_lvl = output_initial_level_a;                          // [RL6]
      end else if (run && a_match && (mode == `ETOC_MODE_CMP)) begin
         case (action)                                       // [RL1] [RL2]
            `ETOC_ACT_LOW:    nxt_lvl = 1'b0;
            `ETOC_ACT_HIGH:   nxt_lvl = 1'b1;
            `ETOC_ACT_TOGGLE: nxt_lvl = ~lvl_ff;
            default:          nxt_lvl = lvl_ff;
         endcase
      end
      if (run && a_match && (mode == `ETOC_MODE_PWM)) begin
         nxt_pulse = 1'b0;
      end
   end

   always @* begin
      raw = 1'b0;
      case (mode)
         `ETOC_MODE_CMP: raw = lvl_ff;
         `ETOC_MODE_PWM: begin
            case (action)
               `ETOC_PACT_INACT: raw = inact;
               `ETOC_PACT_ACT:   raw = act;
               `ETOC_PACT_PWM:   raw = (run && below_a) ? act : inact;
               default:          raw = (run && pulse_ff) ? act : inact;
            endcase
         end
         // Timer mode: level and polarity bits have no say [RL8] [RL9]
         default:        raw = 1'b0;
      endcase
   end

   // Pin registered after the polarity stage [RL15]
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lvl_ff   <= 1'b0;
         pulse_ff <= 1'b0;
         pin_ff   <= 1'b0;
         oe_ff    <= 1'b0;
      end else begin
         lvl_ff   <= nxt_lvl;
         pulse_ff <= nxt_pulse;
         if (mode == `ETOC_MODE_TMR) begin
            pin_ff <= 1'b0;                                         // [RL9]
         end else begin
            pin_ff <= raw ^ output_invert_a;                 // [RL9] [RL15]
         end
         oe_ff    <= (mode == `ETOC_MODE_CMP) || (mode == `ETOC_MODE_PWM);
      end
   end

   assign output_pin_a_o  = pin_ff;
   assign output_pin_a_oe = oe_ff;
endmodule // etoc_out_a

/* File: dv/etoc_top_sva.sv */
// Register-port protocol assertions for the timer output block
`timescale 1ns/10ps
`include "etoc_consts.vh"
module etoc_sva (
   // Clock and reset
   input wire        sys_clk,
   input wire        resetn,
   // Write channels
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   // Read channels
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer lost");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_write_busy: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write answer repeated");
   a_bresp_code: assert property (s_axi_bvalid |->
      s_axi_bresp == `ETOC_RESP_OKAY || s_axi_bresp == `ETOC_RESP_SLVERR)
      else $error("bad write response code");
endmodule // etoc_sva

bind etoc_top etoc_sva u_sva (
   .sys_clk(sys_clk), .resetn(resetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

/* File: dv/etoc_pin_load.sv */
// Load on output pin A that measures its period and high time
`timescale 1ns/10ps
module etoc_pin_load (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // Pin
   input  wire        pin_o,
   input  wire        pin_oe,
   // Measurements
   output reg  [15:0] rise_period,
   output reg  [15:0] high_width,
   output reg  [15:0] rise_count
);
   // Pull-up on the wire, so a released pin reads high
   wire       level = pin_oe ? pin_o : 1'b1;
   reg        last_ff;
   reg [15:0] since_ff;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         last_ff     <= 1'b1;
         since_ff    <= 16'h0000;
         rise_period <= 16'h0000;
         high_width  <= 16'h0000;
         rise_count  <= 16'h0000;
      end else begin
         last_ff  <= level;
         since_ff <= since_ff + 16'h0001;
         if (level && !last_ff) begin
            rise_period <= since_ff;
            since_ff    <= 16'h0001;
            rise_count  <= rise_count + 16'h0001;
         end
         if (!level && last_ff)
            high_width <= since_ff;
      end
   end
endmodule // etoc_pin_load

/* File: dv/test_enhanced_timer_output_ctrl.sv */
// Self-checking bench for the timer output-A control block
`timescale 1ns/10ps
`include "etoc_consts.vh"
module test_enhanced_timer_output_ctrl;
   typedef struct {
      logic [7:0] c1; logic [2:0] p; logic [9:0] a;
      logic [15:0] per; logic [15:0] hi;
   } etoc_row_t;
   reg         sys_clk = 1'b0;
   reg         resetn = 1'b0;
   reg  [4:0]  s_axi_awaddr;
   reg         s_axi_awvalid = 1'b0;
   reg  [31:0] s_axi_wdata;
   reg         s_axi_wvalid = 1'b0;
   reg         s_axi_bready = 1'b0;
   reg  [4:0]  s_axi_araddr;
   reg         s_axi_arvalid = 1'b0;
   reg         s_axi_rready = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire        s_axi_arready, s_axi_rvalid, pin_o, pin_oe;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] per, hi, rises;
   integer     fail_count = 0;
   integer     n_compared = 0;
   integer     i, base;
   reg  [31:0] rd, first;
   reg  [1:0]  rr;
   reg         seen;
   etoc_row_t  rows [0:6];

   always #10 sys_clk = ~sys_clk;

   etoc_top DUT (
      .sys_clk(sys_clk), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .output_pin_a_o(pin_o),
      .output_pin_a_oe(pin_oe));

   etoc_pin_load u_load (.sys_clk(sys_clk), .resetn(resetn),
      .pin_o(pin_o), .pin_oe(pin_oe), .rise_period(per),
      .high_width(hi), .rise_count(rises));

   task complete_run;
      $display("Compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task check(input [31:0] got, input [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h, expected %h", $time,
            got, exp);
         fail_count = fail_count + 1;
      end
   endtask

   // Holds every request until its own handshake edge
   task wr(input [4:0] a, input [31:0] d, input [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      @(posedge sys_clk);
      while (s_axi_bvalid !== 1'b1) begin
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         @(posedge sys_clk);
      end
      check({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task rdreg(input [4:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(posedge sys_clk);
      while (s_axi_rvalid !== 1'b1) begin
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         @(posedge sys_clk);
      end
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task rdchk(input [4:0] a, input [31:0] exp, input [1:0] er);
      rdreg(a);
      check(rd, exp);
      check({30'h0, rr}, {30'h0, er});
   endtask

   // Looks between edges, then realigns to the next rising edge
   task pinchk(input o, input oe);
      #1;
      check({31'h0, pin_o}, {31'h0, o});
      check({31'h0, pin_oe}, {31'h0, oe});
      @(posedge sys_clk);
   endtask

   function [7:0] c1(input [1:0] m, input [1:0] act, input ini,
                     input inv, input clr);
      c1 = {m, act, ini, inv, 1'b0, clr};
   endfunction

   task setup(input [7:0] c, input [2:0] p, input [9:0] a);
      wr(`ETOC_OFS_CTRL0, 32'h0, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CMPA, {22'h0, a}, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL1, {24'h0, c}, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL0, {28'h0, 1'b1, p}, `ETOC_RESP_OKAY);
   endtask

   initial begin
      #1000000;
      fail_count = fail_count + 1;
      complete_run;
   end

   initial begin
      rows[0] = '{c1(`ETOC_MODE_CMP, `ETOC_ACT_TOGGLE, 0, 0, 1), 3'h0,
                  10'h5, 16'hC, 16'h6};
      rows[1] = '{c1(`ETOC_MODE_CMP, `ETOC_ACT_TOGGLE, 0, 0, 1), 3'h0,
                  10'h20, 16'h42, 16'h21};
      rows[2] = '{c1(`ETOC_MODE_CMP, `ETOC_ACT_TOGGLE, 0, 0, 0), 3'h1,
                  10'h5, 16'h102, 16'h81};
      rows[3] = '{c1(`ETOC_MODE_CMP, `ETOC_ACT_TOGGLE, 0, 0, 0), 3'h0,
                  10'h5, 16'h800, 16'h400};
      rows[4] = '{c1(`ETOC_MODE_PWM, `ETOC_PACT_PWM, 1, 0, 1), 3'h1,
                  10'h20, 16'h81, 16'h20};
      rows[5] = '{c1(`ETOC_MODE_PWM, `ETOC_PACT_PWM, 0, 0, 0), 3'h1,
                  10'h20, 16'h81, 16'h61};
      rows[6] = '{c1(`ETOC_MODE_PWM, `ETOC_PACT_PWM, 1, 1, 0), 3'h1,
                  10'h20, 16'h81, 16'h61};
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      pinchk(1'b0, 1'b1);
      for (i = 0; i < 20; i = i + 4)
         rdchk(i[4:0], 32'h0, `ETOC_RESP_OKAY);
      rdchk(5'h14, 32'h0, `ETOC_RESP_SLVERR);
      wr(5'h14, 32'hFF, `ETOC_RESP_SLVERR);
      wr(`ETOC_OFS_CTRL1, 32'h02, `ETOC_RESP_OKAY);
      rdchk(`ETOC_OFS_CTRL1, 32'h0, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL2, 32'h01, `ETOC_RESP_OKAY);
      setup(c1(`ETOC_MODE_PWM, `ETOC_PACT_PWM, 1, 0, 0), 3'h1, 10'h020);
      seen = 1'b0;
      for (i = 0; i < 150; i = i + 1) begin
         rdreg(`ETOC_OFS_CTRL1);
         seen = seen | (rd[1] === 1'b1);
      end
      check({31'h0, seen}, 32'h1);
      wr(`ETOC_OFS_CTRL2, 32'h0, `ETOC_RESP_OKAY);
      for (i = 0; i < 7; i = i + 1) begin
         setup(rows[i].c1, rows[i].p, rows[i].a);
         base = rises;
         while (rises < base + 3) @(posedge sys_clk);
         check({16'h0, per}, {16'h0, rows[i].per});
         check({16'h0, hi}, {16'h0, rows[i].hi});
      end
      wr(`ETOC_OFS_CTRL0, 32'h0, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL1, c1(`ETOC_MODE_CMP, `ETOC_ACT_LOW, 1, 0, 1),
         `ETOC_RESP_OKAY);
      pinchk(1'b1, 1'b1);
      wr(`ETOC_OFS_CTRL0, 32'h8, `ETOC_RESP_OKAY);
      repeat (60) @(posedge sys_clk);
      pinchk(1'b0, 1'b1);
      wr(`ETOC_OFS_CTRL1, c1(`ETOC_MODE_CMP, `ETOC_ACT_NONE, 1, 1, 1),
         `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL0, 32'h0, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL0, 32'h8, `ETOC_RESP_OKAY);
      repeat (80) @(posedge sys_clk);
      pinchk(1'b0, 1'b1);
      wr(`ETOC_OFS_CTRL1, c1(`ETOC_MODE_TMR, `ETOC_ACT_NONE, 1, 1, 0),
         `ETOC_RESP_OKAY);
      pinchk(1'b0, 1'b0);
      wr(`ETOC_OFS_CTRL1, c1(`ETOC_MODE_PWM, `ETOC_PACT_ACT, 1, 0, 0),
         `ETOC_RESP_OKAY);
      pinchk(1'b1, 1'b1);
      wr(`ETOC_OFS_CTRL1, c1(`ETOC_MODE_CAP, 2'h0, 1, 0, 0),
         `ETOC_RESP_OKAY);
      #1;
      check({31'h0, pin_oe}, 32'h0);
      @(posedge sys_clk);
      setup(c1(`ETOC_MODE_CMP, `ETOC_ACT_HIGH, 0, 0, 1), 3'h0, 10'h3FF);
      repeat (1100) @(posedge sys_clk);
      pinchk(1'b1, 1'b1);
      wr(`ETOC_OFS_CTRL0, 32'h0, `ETOC_RESP_OKAY);
      rdreg(`ETOC_OFS_COUNT);
      first = rd;
      repeat (5) @(posedge sys_clk);
      rdchk(`ETOC_OFS_COUNT, first, `ETOC_RESP_OKAY);
      wr(`ETOC_OFS_CTRL0, 32'h8, `ETOC_RESP_OKAY);
      pinchk(1'b0, 1'b1);
      rdreg(`ETOC_OFS_COUNT);
      check({31'h0, rd < 32'h20}, 32'h1);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rdchk(`ETOC_OFS_CTRL1, 32'h0, `ETOC_RESP_OKAY);
      rdchk(`ETOC_OFS_CMPA, 32'h0, `ETOC_RESP_OKAY);
      complete_run;
   end
endmodule // test_enhanced_timer_output_ctrl
